// *** design/esos_pkg.sv ***
// Shared constants and carriers for the event and operation status block.
package esos_pkg;

    // Register widths.
    localparam int EVS_W  = 8;
    localparam int OPER_W = 16;

    // Event status bit positions.
    localparam int EVS_OPC    = 0;
    localparam int EVS_QUERY  = 2;
    localparam int EVS_DEVICE = 3;
    localparam int EVS_EXEC   = 4;
    localparam int EVS_CMD    = 5;
    localparam int EVS_USER   = 6;
    localparam int EVS_PON    = 7;

    // Operation status bit positions.
    localparam int OPER_CAL    = 0;
    localparam int OPER_HCOPY  = 8;
    localparam int OPER_SCAN   = 9;
    localparam int OPER_BREAK  = 10;
    localparam int OPER_THRESH = 12;
    localparam int OPER_ZERO   = 15;

    // Values after reset; the power-on bit starts set.
    localparam logic [EVS_W-1:0]  EVS_RST     = 8'h80;
    localparam logic [EVS_W-1:0]  ESE_RST     = 8'h00;
    localparam logic [OPER_W-1:0] OPER_RST    = 16'h0000;
    localparam logic [OPER_W-1:0] OPER_EN_RST = 16'h0000;
    localparam logic              FEED_RST    = 1'b0;

    // Error code windows and fallback codes, two's complement.
    localparam logic signed [15:0] DEV_LO   = 16'shfe71;
    localparam logic signed [15:0] DEV_HI   = 16'shfed4;
    localparam logic signed [15:0] EXE_LO   = 16'shfed5;
    localparam logic signed [15:0] EXE_HI   = 16'shff38;
    localparam logic signed [15:0] CMD_LO   = 16'shff39;
    localparam logic signed [15:0] CMD_HI   = 16'shff9c;
    localparam logic signed [15:0] DEV_DFLT = 16'shfed4;
    localparam logic signed [15:0] EXE_DFLT = 16'shff38;
    localparam logic signed [15:0] CMD_DFLT = 16'shff9c;

    // Controller command strobes, one cycle each.
    typedef struct packed {
        logic evs_rd;
        logic ese_rd;
        logic ese_wr;
        logic cond_rd;
        logic evt_rd;
        logic oen_rd;
        logic oen_wr;
        logic feed_wr;
    } esos_cmd_t;

    // Error report: a push strobe and its queue code.
    typedef struct packed {
        logic              push;
        logic signed [15:0] code;
    } esos_err_t;

    // Scan flow state.
    typedef enum logic {
        MEAS_RUN,
        MEAS_PAUSED
    } esos_meas_t;

endpackage

// *** design/esos_sticky.sv ***
`timescale 1ns/1ns
// Sticky event bits that clear on a read; a set in the read cycle survives.
module esos_sticky #(
    parameter int              W   = 8,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic         rd_clr_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] q_r;   // Latched event bits.
    logic [W-1:0] q_nxt; // Next latched bits.

    // Clear on read first, then OR in new events so the set wins.
    always_comb begin
        q_nxt = (rd_clr_i ? '0 : q_r) | set_i;
    end

    // Register the latched bits.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule

// *** design/esos_rise.sv ***
`timescale 1ns/1ns
// Rising transition detector; the output is combinational on the live input.
module esos_rise #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] lvl_i,
    output logic      [W-1:0] rise_o
);

    logic [W-1:0] prev_r;   // Level seen on the previous edge.
    logic [W-1:0] prev_nxt; // Next stored level.

    // Remember the current level for the next comparison.
    always_comb begin
        prev_nxt = lvl_i;
    end

    // Register the level; starting low means a level high at release counts as a rise.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise_o = lvl_i & ~prev_r;

endmodule

// *** design/esos_status.sv ***
`timescale 1ns/1ns
// What this block does
// - Operation complete sets bit 0 once idle.
// - Query error sets bit 2.
// - Device fault sets bit 3, queues code unless an execution or command fault comes in the same cycle.
// - Execution fault sets bit 4, queues code unless a command fault comes in the same cycle.
// - Command fault sets bit 5, queues code.
// - Local key sets bit 6.
// - Power-up sets bit 7.
// - Controller-written enable mask for event bits.
// - Condition bit 0 follows calibration.
// - Condition bit 8 follows hardcopy printing.
// - Bit 9 reports scan blocks when feeding.
// - Range end sets bit 10, pauses until continue.
// - Bit 15 zero, unused zero, 12 threshold.
// - Condition view plus since-last-read event view.
// - Event summary bit from enabled event bits.
// - Operation summary from enabled operation events.
module esos_status (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire esos_pkg::esos_cmd_t  cmd_i,
    input  wire logic [15:0]          wdata_i,
    input  wire logic                 opc_cmd_i,
    input  wire logic                 cmds_idle_i,
    input  wire logic                 output_rd_i,
    input  wire logic                 query_pending_i,
    input  wire logic                 new_cmd_i,
    input  wire logic                 response_unfetched_i,
    input  wire esos_pkg::esos_err_t  dev_err_i,
    input  wire esos_pkg::esos_err_t  exe_err_i,
    input  wire esos_pkg::esos_err_t  cmd_err_i,
    input  wire logic                 local_key_i,
    input  wire logic                 calibration_active_i,
    input  wire logic                 hardcopy_active_i,
    input  wire logic                 scan_results_ready_i,
    input  wire logic                 scan_range_end_i,
    input  wire logic                 continue_measurement_cmd_i,
    input  wire logic                 threshold_active_i,
    output logic [15:0]               rdata_o,
    output logic                      rvalid_o,
    output esos_pkg::esos_err_t       err_o,
    output logic                      event_summary_bit_o,
    output logic                      oper_summary_o,
    output logic                      meas_paused_o,
    output logic                      continuous_result_feed_o
);

    // Tell whether a code lies inside an inclusive window.
    function automatic logic in_win(input logic signed [15:0] c,
                                    input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
        in_win = (c >= lo) && (c <= hi);
    endfunction

    logic [esos_pkg::EVS_W-1:0]  evs_q;      // Latched event status.
    logic [esos_pkg::EVS_W-1:0]  evs_set;    // Event status set terms.
    logic [esos_pkg::OPER_W-1:0] oper_cond;  // Operation condition view.
    logic [esos_pkg::OPER_W-1:0] oper_rise;  // Positive transitions of the condition.
    logic [esos_pkg::OPER_W-1:0] oper_evt;   // Operation event view.
    logic                        key_rise;   // Local key press edge.
    logic                        opc_hit;    // Operation complete fires this cycle.
    logic                        query_hit;  // Query error detected this cycle.

    // Control registers written by the controller.
    logic [esos_pkg::EVS_W-1:0]  ese_r,  ese_nxt;   // Event status enable mask.
    logic [esos_pkg::OPER_W-1:0] oen_r,  oen_nxt;   // Operation event enable mask.
    logic                        feed_r, feed_nxt;  // Continuous result feeding.
    logic                        opc_pend_r, opc_pend_nxt; // Waiting for idle.
    esos_pkg::esos_meas_t        meas_r, meas_nxt;  // Scan flow state.

    // Read port and error queue registers.
    logic [15:0]                 rdata_nxt;
    logic                        rvalid_nxt;
    esos_pkg::esos_err_t         err_r, err_nxt;

    // Control state: masks, feed switch, pending operation complete and pause.
    always_comb begin
        ese_nxt      = ese_r;
        oen_nxt      = oen_r;
        feed_nxt     = feed_r;
        opc_pend_nxt = opc_pend_r;
        meas_nxt     = meas_r;
        if (cmd_i.ese_wr) begin
            ese_nxt = wdata_i[esos_pkg::EVS_W-1:0];
        end
        if (cmd_i.oen_wr) begin
            oen_nxt = wdata_i;
        end
        if (cmd_i.feed_wr) begin
            feed_nxt = wdata_i[0];
        end
        // A request made while already idle fires at once and leaves nothing pending.
        if (opc_hit) begin
            opc_pend_nxt = 1'b0;
        end else if (opc_cmd_i) begin
            opc_pend_nxt = 1'b1;
        end
        // Continue in the same cycle as a new range end keeps the scan paused.
        unique case (meas_r)
            esos_pkg::MEAS_RUN: begin
                if (scan_range_end_i) begin
                    meas_nxt = esos_pkg::MEAS_PAUSED;
                end
            end
            esos_pkg::MEAS_PAUSED: begin
                if (continue_measurement_cmd_i && !scan_range_end_i) begin
                    meas_nxt = esos_pkg::MEAS_RUN;
                end
            end
        endcase
    end

    // Register the control state.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ese_r      <= esos_pkg::ESE_RST;
            oen_r      <= esos_pkg::OPER_EN_RST;
            feed_r     <= esos_pkg::FEED_RST;
            opc_pend_r <= 1'b0;
            meas_r     <= esos_pkg::MEAS_RUN;
        end else begin
            ese_r      <= ese_nxt;
            oen_r      <= oen_nxt;
            feed_r     <= feed_nxt;
            opc_pend_r <= opc_pend_nxt;
            meas_r     <= meas_nxt;
        end
    end

    // Detect presses of the local key.
    esos_rise #(.W(1)) u_key_rise (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .lvl_i   (local_key_i),
        .rise_o  (key_rise)
    );

    // Event status set terms; the power-on bit comes only from the reset value.
    assign opc_hit   = (opc_pend_r || opc_cmd_i) && cmds_idle_i;
    assign query_hit = (output_rd_i && !query_pending_i) ||
                       (new_cmd_i && response_unfetched_i);
    always_comb begin
        evs_set                        = '0;
        evs_set[esos_pkg::EVS_OPC]     = opc_hit;
        evs_set[esos_pkg::EVS_QUERY]   = query_hit;
        evs_set[esos_pkg::EVS_DEVICE]  = dev_err_i.push;
        evs_set[esos_pkg::EVS_EXEC]    = exe_err_i.push;
        evs_set[esos_pkg::EVS_CMD]     = cmd_err_i.push;
        evs_set[esos_pkg::EVS_USER]    = key_rise;
    end

    // Event status register, power-on bit set out of reset.
    esos_sticky #(.W(esos_pkg::EVS_W), .RST(esos_pkg::EVS_RST)) u_evs (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .set_i    (evs_set),
        .rd_clr_i (cmd_i.evs_rd),
        .q_o      (evs_q)
    );

    // Operation condition view; unused bits and bit 15 stay zero.
    always_comb begin
        oper_cond                        = '0;
        oper_cond[esos_pkg::OPER_CAL]    = calibration_active_i;
        oper_cond[esos_pkg::OPER_HCOPY]  = hardcopy_active_i;
        oper_cond[esos_pkg::OPER_SCAN]   = scan_results_ready_i && feed_r;
        oper_cond[esos_pkg::OPER_BREAK]  = (meas_r == esos_pkg::MEAS_PAUSED);
        oper_cond[esos_pkg::OPER_THRESH] = threshold_active_i;
    end

    // Events record rises of the condition since the last event read.
    esos_rise #(.W(esos_pkg::OPER_W)) u_oper_rise (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .lvl_i   (oper_cond),
        .rise_o  (oper_rise)
    );

    esos_sticky #(.W(esos_pkg::OPER_W), .RST(esos_pkg::OPER_RST)) u_oper_evt (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .set_i    (oper_rise),
        .rd_clr_i (cmd_i.evt_rd),
        .q_o      (oper_evt)
    );

    // Summaries are combinational so they follow the latched bits at once.
    assign event_summary_bit_o = |(evs_q & ese_r);
    assign oper_summary_o      = |(oper_evt & oen_r);

    // Read mux and error queue push. Only one error is pushed per cycle, command faults first;
    // the others still set their event bits, which is the cheaper trade against a queue here.
    always_comb begin
        rdata_nxt  = '0;
        rvalid_nxt = 1'b1;
        err_nxt    = '0;
        if (cmd_i.evs_rd) begin
            rdata_nxt = {8'h00, evs_q};
        end else if (cmd_i.ese_rd) begin
            rdata_nxt = {8'h00, ese_r};
        end else if (cmd_i.cond_rd) begin
            rdata_nxt = oper_cond;
        end else if (cmd_i.evt_rd) begin
            rdata_nxt = oper_evt;
        end else if (cmd_i.oen_rd) begin
            rdata_nxt = oen_r;
        end else begin
            rvalid_nxt = 1'b0;
        end
        if (cmd_err_i.push) begin
            err_nxt.push = 1'b1;
            err_nxt.code = in_win(cmd_err_i.code, esos_pkg::CMD_LO, esos_pkg::CMD_HI) ?
                           cmd_err_i.code : esos_pkg::CMD_DFLT;
        end else if (exe_err_i.push) begin
            err_nxt.push = 1'b1;
            err_nxt.code = in_win(exe_err_i.code, esos_pkg::EXE_LO, esos_pkg::EXE_HI) ?
                           exe_err_i.code : esos_pkg::EXE_DFLT;
        end else if (dev_err_i.push) begin
            err_nxt.push = 1'b1;
            // Positive codes refine the fault and pass through unchanged.
            err_nxt.code = (in_win(dev_err_i.code, esos_pkg::DEV_LO, esos_pkg::DEV_HI) ||
                            dev_err_i.code > 16'sh0000) ? dev_err_i.code : esos_pkg::DEV_DFLT;
        end
    end

    // Register read data and error output.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o  <= '0;
            rvalid_o <= 1'b0;
            err_r    <= '0;
        end else begin
            rdata_o  <= rdata_nxt;
            rvalid_o <= rvalid_nxt;
            err_r    <= err_nxt;
        end
    end

    assign err_o                    = err_r;
    assign meas_paused_o            = (meas_r == esos_pkg::MEAS_PAUSED);
    assign continuous_result_feed_o = feed_r;

    // Assertions.
    sequence s_dev_only;
        dev_err_i.push && !exe_err_i.push && !cmd_err_i.push;
    endsequence

    sequence s_dev_queued;
        err_o.push && evs_q[esos_pkg::EVS_DEVICE] &&
        ((err_o.code >= esos_pkg::DEV_LO && err_o.code <= esos_pkg::DEV_HI) || err_o.code > 16'sh0000);
    endsequence

    sequence s_break_seen;
        scan_range_end_i ##1 meas_paused_o;
    endsequence

    AST_OPC_WAITS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        opc_cmd_i && !cmds_idle_i && !evs_q[esos_pkg::EVS_OPC]
        |=> opc_pend_r && !evs_q[esos_pkg::EVS_OPC])
        else $error("operation complete not held pending");

    AST_OPC_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        opc_pend_r && cmds_idle_i |=> evs_q[esos_pkg::EVS_OPC] && !opc_pend_r)
        else $error("operation complete bit missing");

    AST_QUERY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        output_rd_i && !query_pending_i |=> evs_q[esos_pkg::EVS_QUERY])
        else $error("query error bit missing");

    AST_DEV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_dev_only |=> s_dev_queued)
        else $error("device fault not reported");

    AST_EXE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        exe_err_i.push && !cmd_err_i.push |=> err_o.push && evs_q[esos_pkg::EVS_EXEC] &&
        err_o.code >= esos_pkg::EXE_LO && err_o.code <= esos_pkg::EXE_HI)
        else $error("execution fault not reported");

    AST_CMD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cmd_err_i.push |=> err_o.push && evs_q[esos_pkg::EVS_CMD] &&
        err_o.code >= esos_pkg::CMD_LO && err_o.code <= esos_pkg::CMD_HI)
        else $error("command fault not reported");

    AST_USER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(local_key_i) |=> evs_q[esos_pkg::EVS_USER])
        else $error("local key press not recorded");

    AST_CAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        calibration_active_i ##1 !calibration_active_i |-> !oper_cond[esos_pkg::OPER_CAL])
        else $error("calibration bit outlives calibration");

    AST_FEED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        scan_results_ready_i && !continuous_result_feed_o |-> !oper_cond[esos_pkg::OPER_SCAN])
        else $error("scan bit reported without feeding");

    AST_BREAK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_break_seen ##0 !continue_measurement_cmd_i [*2] |=> meas_paused_o)
        else $error("scan resumed without continue");

    AST_ZERO15: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !oper_cond[esos_pkg::OPER_ZERO] && !oper_evt[esos_pkg::OPER_ZERO] &&
        oper_cond[esos_pkg::OPER_THRESH] == threshold_active_i)
        else $error("operation bit 15 or 12 wrong");

    AST_EVT_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cmd_i.evt_rd && $stable(oper_cond) && $past(rst_n_i) |=> oper_evt == '0)
        else $error("operation event not cleared by read");

    AST_SUMMARY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(hardcopy_active_i) && oen_r[esos_pkg::OPER_HCOPY] && !cmd_i.evt_rd
        && !cmd_i.oen_wr |=> oper_summary_o)
        else $error("operation summary missing");

    AST_EVS_SUM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        dev_err_i.push && ese_r[esos_pkg::EVS_DEVICE] && !cmd_i.ese_wr |=> event_summary_bit_o)
        else $error("event summary bit missing");

endmodule

// *** testbench/esos_ctrl_model.sv ***
`timescale 1ns/1ns
// Controller model that resumes a paused scan after a fixed think time.
module esos_ctrl_model #(
    parameter int DELAY = 6
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic meas_paused_i,
    output logic      continue_measurement_cmd_o
);
    int wait_r; // Cycles spent so far waiting to answer a pause.

    // A real controller answers late, so the pause must hold on its own meanwhile.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 0;
            continue_measurement_cmd_o <= 1'b0;
        end else begin
            continue_measurement_cmd_o <= 1'b0;
            if (!meas_paused_i || continue_measurement_cmd_o) begin
                wait_r <= 0;
            end else if (wait_r == DELAY) begin
                continue_measurement_cmd_o <= 1'b1;
                wait_r <= 0;
            end else begin
                wait_r <= wait_r + 1;
            end
        end
    end
endmodule

// *** testbench/test_esos_status.sv ***
`timescale 1ns/1ns
// Compares two values, counts the check and reports a difference at once.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
// Self-checking bench for the status block, with a controller model resuming scans.
module test_esos_status;
    localparam logic [7:0] K_EVS = 8'h80, K_ESE_RD = 8'h40, K_ESE_WR = 8'h20, K_COND = 8'h10;
    localparam logic [7:0] K_EVT = 8'h08, K_OEN_RD = 8'h04, K_OEN_WR = 8'h02, K_FEED = 8'h01;
    logic                clk_i = 1'b0;    // System clock.
    logic                rst_n_i = 1'b0;  // Reset, active low.
    esos_pkg::esos_cmd_t cmd = '0;        // Command strobes.
    logic [15:0]         wdata = '0;      // Write data.
    logic                opc = 1'b0, idle = 1'b0, out_rd = 1'b0, q_pend = 1'b0;
    logic                new_cmd = 1'b0, unfetched = 1'b0, key = 1'b0, cal = 1'b0;
    logic                hcopy = 1'b0, scan_rdy = 1'b0, range_end = 1'b0, thresh = 1'b0;
    esos_pkg::esos_err_t dev_err = '0, exe_err = '0, cmd_err = '0; // Fault reports.
    logic                cont;            // Continue command from the model.
    logic [15:0]         rdata_o;
    logic                rvalid_o, evs_sum, oper_sum, paused, feed;
    esos_pkg::esos_err_t err_o;
    int                  mismatches = 0, tests_run = 0;
    int                  seed = 32'h2aea99c1; // Fixed seed keeps runs repeatable.
    logic signed [15:0]  code;
    int                  k;

    // Free-running clock, 100 MHz.
    always #5 clk_i = ~clk_i;

    esos_status i_esos_status (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .wdata_i(wdata),
        .opc_cmd_i(opc), .cmds_idle_i(idle), .output_rd_i(out_rd), .query_pending_i(q_pend),
        .new_cmd_i(new_cmd), .response_unfetched_i(unfetched), .dev_err_i(dev_err),
        .exe_err_i(exe_err), .cmd_err_i(cmd_err), .local_key_i(key), .calibration_active_i(cal),
        .hardcopy_active_i(hcopy), .scan_results_ready_i(scan_rdy), .scan_range_end_i(range_end),
        .continue_measurement_cmd_i(cont), .threshold_active_i(thresh), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .err_o(err_o), .event_summary_bit_o(evs_sum), .oper_summary_o(oper_sum),
        .meas_paused_o(paused), .continuous_result_feed_o(feed));

    esos_ctrl_model #(.DELAY(6)) i_esos_ctrl_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .meas_paused_i(paused), .continue_measurement_cmd_o(cont));

    // Code the block should hand to the queue: in-window codes and positive device codes pass, others fall back.
    function automatic logic signed [15:0] exp_code(input int kind, input logic signed [15:0] c);
        case (kind)
            0: return ((c >= esos_pkg::DEV_LO && c <= esos_pkg::DEV_HI) || c > 0) ? c : esos_pkg::DEV_DFLT;
            1: return (c >= esos_pkg::EXE_LO && c <= esos_pkg::EXE_HI) ? c : esos_pkg::EXE_DFLT;
            default: return (c >= esos_pkg::CMD_LO && c <= esos_pkg::CMD_HI) ? c : esos_pkg::CMD_DFLT;
        endcase
    endfunction

    // One strobe for one cycle; the answer is looked at in the cycle after the taking edge.
    task automatic acc(input logic [7:0] c, input logic [15:0] wd);
        @(posedge clk_i);
        cmd   <= esos_pkg::esos_cmd_t'(c);
        wdata <= wd;
        @(posedge clk_i);
        cmd <= '0;
        #1;
    endtask

    // Read one register and compare the answer.
    task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
        acc(c, 16'h0000);
        `CHK(rvalid_o, 1'b1)
        `CHK(rdata_o, exp)
    endtask

    // Wait a few whole cycles, leaving the last edge's updates time to land.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watchdog sized well beyond the fewer than two hundred cycles the tests need.
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    // Main test sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(K_EVS, 16'h0080);
        rdchk(K_EVS, 16'h0000);
        $display("test power-on done");
        @(posedge clk_i) opc <= 1'b1;
        @(posedge clk_i) opc <= 1'b0;
        cyc(3);
        rdchk(K_EVS, 16'h0000);
        @(posedge clk_i) idle <= 1'b1;
        cyc(2);
        rdchk(K_EVS, 16'h0001);
        @(posedge clk_i) out_rd <= 1'b1;
        @(posedge clk_i) out_rd <= 1'b0;
        rdchk(K_EVS, 16'h0004);
        @(posedge clk_i) begin
            new_cmd <= 1'b1;
            unfetched <= 1'b1;
        end
        @(posedge clk_i) new_cmd <= 1'b0;
        rdchk(K_EVS, 16'h0004);
        @(posedge clk_i) key <= 1'b1;
        cyc(2);
        rdchk(K_EVS, 16'h0040);
        rdchk(K_EVS, 16'h0000);
        // A request made while already idle completes at once.
        @(posedge clk_i) opc <= 1'b1;
        @(posedge clk_i) opc <= 1'b0;
        rdchk(K_EVS, 16'h0001);
        $display("test event sources done");
        acc(K_ESE_WR, 16'h0008);
        rdchk(K_ESE_RD, 16'h0008);
        for (int i = 0; i < 15; i++) begin
            k = i % 3;
            code = 16'($random(seed));
            if (i % 2 == 0) code = 16'(-16'sd100 - 16'sd100 * (2 - k) - $unsigned($random(seed)) % 100);
            @(posedge clk_i);
            case (k)
                0: dev_err <= '{push: 1'b1, code: code};
                1: exe_err <= '{push: 1'b1, code: code};
                default: cmd_err <= '{push: 1'b1, code: code};
            endcase
            @(posedge clk_i);
            dev_err.push <= 1'b0;
            exe_err.push <= 1'b0;
            cmd_err.push <= 1'b0;
            #1;
            `CHK(err_o.push, 1'b1)
            `CHK(err_o.code, exp_code(k, code))
            `CHK(evs_sum, (k == 0))
            rdchk(K_EVS, 16'(16'h0008 << k));
            `CHK(evs_sum, 1'b0)
        end
        // All three faults at once: one code is queued, every event bit still sets.
        @(posedge clk_i) begin
            dev_err <= '{push: 1'b1, code: -16'sd350};
            exe_err <= '{push: 1'b1, code: -16'sd250};
            cmd_err <= '{push: 1'b1, code: -16'sd150};
        end
        @(posedge clk_i) begin
            dev_err.push <= 1'b0;
            exe_err.push <= 1'b0;
            cmd_err.push <= 1'b0;
        end
        #1;
        `CHK(err_o.push, 1'b1)
        `CHK(err_o.code, -16'sd150)
        rdchk(K_EVS, 16'h0038);
        $display("test faults done");
        acc(K_OEN_WR, 16'h8100);
        acc(K_FEED, 16'h0001);
        `CHK(feed, 1'b1)
        @(posedge clk_i) begin
            cal <= 1'b1;
            hcopy <= 1'b1;
            thresh <= 1'b1;
            scan_rdy <= 1'b1;
        end
        cyc(2);
        `CHK(oper_sum, 1'b1)
        rdchk(K_COND, 16'h1301);
        rdchk(K_EVT, 16'h1301);
        rdchk(K_EVT, 16'h0000);
        `CHK(oper_sum, 1'b0)
        @(posedge clk_i) cal <= 1'b0;
        acc(K_FEED, 16'h0000);
        rdchk(K_COND, 16'h1100);
        rdchk(K_OEN_RD, 16'h8100);
        $display("test operation done");
        @(posedge clk_i) range_end <= 1'b1;
        @(posedge clk_i) range_end <= 1'b0;
        #1;
        `CHK(paused, 1'b1)
        rdchk(K_COND, 16'h1500);
        for (int n = 0; n < 20 && paused === 1'b1; n++) cyc(1);
        `CHK(paused, 1'b0)
        rdchk(K_EVT, 16'h0400);
        $display("test scan break done");
        report_and_stop();
    end
endmodule
